/* File: hw/wpec_pkg.sv */
// Purpose: Shared constants and types of the wake and power event control.
// Assumes: 200 MHz standby clock, AXI4-Lite register access.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package wpec_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned RSM_DELAY_MS  = 100;
   localparam int unsigned RSM_DELAY_CYC =
      (RSM_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PB_PULSE_MS   = 50;
   localparam int unsigned PB_PULSE_CYC  =
      PB_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 25;

   // Register offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STAT_A  = 8'h04;
   localparam logic [7:0] OFS_STAT_B  = 8'h08;
   localparam logic [7:0] OFS_EN_A    = 8'h0C;
   localparam logic [7:0] OFS_EN_B    = 8'h10;
   localparam logic [7:0] OFS_PW_IDX  = 8'h14;
   localparam logic [7:0] OFS_PW_DATA = 8'h18;
   localparam logic [7:0] OFS_INFO    = 8'h1C;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Wake sources: bits 3:0 in status A, bits 8:4 in status B
   localparam int unsigned N_SRC       = 9;
   localparam logic [8:0]  SRC_S3_MASK = 9'h00F;

   // Password storage
   localparam int unsigned PW_SETS   = 3;
   localparam int unsigned PW_LEN    = 15;
   localparam int unsigned PW_BYTES  = PW_SETS * PW_LEN;
   localparam logic [3:0]  PW_HI0    = 4'h0;
   localparam logic [3:0]  PW_HI1    = 4'h3;
   localparam logic [3:0]  PW_HI2    = 4'h4;
   localparam logic [7:0]  KEY_BREAK = 8'hF0;

   // Restore policy and infrared flag clear codes
   localparam logic [1:0] POL_OFF  = 2'h0;
   localparam logic [1:0] POL_ON   = 2'h1;
   localparam logic [1:0] POL_PREV = 2'h2;
   localparam logic [1:0] POL_USER = 2'h3;
   localparam logic [1:0] CIR_ARM  = 2'h3;
   localparam logic [1:0] CIR_FIRE = 2'h0;

   typedef enum logic [1:0] {
      SEQ_DOWN    = 2'h0,
      SEQ_DELAY   = 2'h1,
      SEQ_RESTORE = 2'h3,
      SEQ_UP      = 2'h2
   } wpec_seq_e;

   // Control register, bit 0 at the bottom
   typedef struct packed {
      logic [1:0] cir_clr;
      logic       user_off;
      logic [1:0] policy;
      logic       ms_single;
      logic       ms_right;
      logic       ms_any;
      logic       ms_en;
      logic       kbd_en;
      logic       kbd_any;
      logic       gen_en;
   } wpec_ctrl_s;
   localparam wpec_ctrl_s CTRL_RST = 12'h052;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } wpec_axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } wpec_axi_rsp_s;

   typedef struct packed {
      logic uart_irq;
      logic ir_irq;
      logic hwm_irq;
      logic watchdog_timeout_event;
      logic uart_ring_indicate;
      logic consumer_infrared;
      logic wake_capable_gpio;
   } wpec_src_s;

   typedef struct packed {
      logic       kbd_valid;
      logic [7:0] kbd_byte;
      logic       ms_valid;
      logic       ms_left;
      logic       ms_right;
      logic       ms_move;
   } wpec_ps2_s;

   typedef struct packed {
      wpec_axi_rsp_s                 rsp;
      logic                          awf;
      logic                          wf;
      logic [7:0]                    awa;
      logic [31:0]                   wd;
      logic [3:0]                    ws;
      wpec_ctrl_s                    ctrl;
      logic [N_SRC-1:0]              stat;
      logic [N_SRC-1:0]              en;
      logic [7:0]                    pw_idx;
      logic [PW_BYTES-1:0][7:0]      pw;
      logic [PW_SETS-1:0][3:0]       ptr;
      logic                          anybrk;
      logic [1:0]                    ms_prev;
      logic                          ms_cnt;
      logic                          gpio_q;
      logic                          cir_flag;
      logic                          cir_arm;
      logic                          prev_on;
      logic                          mains_q;
      wpec_seq_e                     seq;
      logic [CNT_W-1:0]              cnt;
      logic [CNT_W-1:0]              pb_cnt;
      logic                          wake_n;
      logic                          pbo_n;
      logic                          son_n;
      logic                          rsm_n;
   } wpec_st_s;

   localparam wpec_st_s ST_RST = '{ctrl: CTRL_RST, seq: SEQ_DOWN,
      wake_n: 1'b1, pbo_n: 1'b1, son_n: 1'b1, default: '0};
endpackage : wpec_pkg

/* File: hw/wpec_top.sv */
// Purpose: Wake event collection, power button pass-through, AC restore
//          policy and resume reset timing on the standby domain.
// Assumes: All pin inputs synchronous to clk; keyboard bytes and mouse
//          packets arrive as one-cycle valid strobes.
// Notes:   Outputs are registered, so every pin follows one cycle late.
// How it works
// - Global wake enable low keeps the wake line high regardless of sources.
// - Each wake source has its own sticky flag over two status registers.
// - Writing one to a status flag clears it; software clears before enabling.
// - Two enable registers, one bit per source, gate the wake line.
// - Mouse, keyboard, GPIO, infrared, UART, IR, monitor, watchdog, ring.
// - All sources work awake; only mouse, keyboard, GPIO, infrared in S3-S5.
// - The wake line to the chipset can wake from S1 through S5.
// - Power button out follows power button in low, for the same length.
// - Restore policy: 00 off, 01 on, 10 previous state, 11 software state.
// - Under software policy a bit picks the state: 0 on, 1 off.
// - Previous state is sampled from the S3 sleep signal as main power falls.
// - A qualifying key or mouse event in S3-S5 pulses the power button output low.
// - Keyboard wake works only while its enable bit is one.
// - Three password sets reached through an index and a data register.
// - Each key is a make byte then an F0 prefix and the make byte.
// - Mouse wake works only while its enable bit is one.
// - Three mouse select bits choose activity, one click or two clicks.
// - Resume reset rises 100 to 200 ms after standby power is valid.
// - Resume reset drops at once when standby power goes invalid.
// - Infrared flag is one after a wake; write 11b then 00b to clear it.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wpec_top import wpec_pkg::*; #(
   parameter int unsigned RSM_CYC = RSM_DELAY_CYC,
   parameter int unsigned PB_CYC  = PB_PULSE_CYC
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire wpec_axi_req_s axi_req,
   output var  wpec_axi_rsp_s axi_rsp,
   input  wire wpec_src_s     src,
   input  wire wpec_ps2_s     ps2,
   input  wire logic          power_button_in_n,
   input  wire logic          sleep_state3_n,
   input  wire logic          main_supply_ok,
   input  wire logic          standby_supply_ok,
   output logic               wake_event_out_n,
   output logic               power_button_out_n,
   output logic               supply_on_n,
   output logic               resume_reset_n
);

   wpec_st_s    s;
   wpec_st_s    n;
   logic        wr;
   logic [32:0] wold;
   logic [32:0] rv;
   logic [31:0] wm;
   logic [31:0] cm;
   logic [6:0]  slot;
   logic [8:0]  set;
   logic [8:0]  clr;
   logic        kb_hit;
   logic        ms_hit;
   logic        cl;
   logic        cr;
   logic        ck;
   logic        turn_on;
   logic [5:0]  pi;
   logic [3:0]  np;

   // Password index to storage slot; bit 6 flags a mapped index
   function automatic logic [6:0] pw_slot(input logic [7:0] idx);
      if (idx[3:0] == 4'hF) return 7'h00;
      if (idx[7:4] == PW_HI0) return {3'h4, idx[3:0]};
      if (idx[7:4] == PW_HI1) return {1'b1, 6'(PW_LEN) + {2'h0, idx[3:0]}};
      if (idx[7:4] == PW_HI2) return {1'b1, 6'(2 * PW_LEN) + {2'h0, idx[3:0]}};
      return 7'h00;
   endfunction : pw_slot

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction : merge

   // Register read view; bit 32 marks an unmapped address
   function automatic logic [32:0] rd_val(input logic [7:0] a);
      logic [6:0] sl;
      sl = pw_slot(s.pw_idx);
      unique case (a)
         OFS_CTRL:    return {21'h0, s.ctrl};
         OFS_STAT_A:  return {29'h0, s.stat[3:0]};
         OFS_STAT_B:  return {28'h0, s.stat[8:4]};
         OFS_EN_A:    return {29'h0, s.en[3:0]};
         OFS_EN_B:    return {28'h0, s.en[8:4]};
         OFS_PW_IDX:  return {25'h0, s.pw_idx};
         OFS_PW_DATA: return {25'h0, sl[6] ? s.pw[sl[5:0]] : 8'h00};
         OFS_INFO:    return {29'h0, s.seq, s.prev_on, s.cir_flag};
         default:     return {1'b1, 32'h0};
      endcase
   endfunction : rd_val

   // Next-state logic of the whole block
   always_comb begin
      n       = s;
      set     = '0;
      clr     = '0;
      kb_hit  = 1'b0;
      ms_hit  = 1'b0;
      turn_on = 1'b0;
      pi      = '0;
      np      = '0;
      rv      = '0;
      slot    = pw_slot(s.pw_idx);
      wold    = rd_val(s.awa);
      wm      = merge(wold[31:0], s.wd, s.ws);
      cm      = merge(32'h0, s.wd, s.ws);
      wr      = s.awf & s.wf & ~s.rsp.bvalid;

      // Bus responses retire on their handshake
      if (s.rsp.bvalid && axi_req.bready) n.rsp.bvalid = 1'b0;
      if (s.rsp.rvalid && axi_req.rready) n.rsp.rvalid = 1'b0;

      // Address and data both held: commit the write
      if (wr) begin
         n.awf         = 1'b0;
         n.wf          = 1'b0;
         n.rsp.bvalid  = 1'b1;
         n.rsp.bresp   = wold[32] ? RESP_SLVERR : RESP_OKAY;
         unique case (s.awa)
            OFS_CTRL:    n.ctrl = wpec_ctrl_s'(wm[11:0]);
            OFS_STAT_A:  clr[3:0] = cm[3:0];
            OFS_STAT_B:  clr[8:4] = cm[4:0];
            OFS_EN_A:    n.en[3:0] = wm[3:0];
            OFS_EN_B:    n.en[8:4] = wm[4:0];
            OFS_PW_IDX:  n.pw_idx = wm[7:0];
            OFS_PW_DATA: begin
               if (slot[6]) n.pw[slot[5:0]] = wm[7:0];
            end
            default: ;
         endcase
      end
      if (axi_req.awvalid && s.rsp.awready) begin
         n.awf = 1'b1;
         n.awa = axi_req.awaddr;
      end
      if (axi_req.wvalid && s.rsp.wready) begin
         n.wf = 1'b1;
         n.wd = axi_req.wdata;
         n.ws = axi_req.wstrb;
      end
      if (axi_req.arvalid && s.rsp.arready) begin
         rv          = rd_val(axi_req.araddr);
         n.rsp.rvalid = 1'b1;
         n.rsp.rdata  = rv[31:0];
         n.rsp.rresp  = rv[32] ? RESP_SLVERR : RESP_OKAY;
      end
      // One write and one read in flight; ready drops while answering
      n.rsp.awready = ~n.awf & ~n.rsp.bvalid;
      n.rsp.wready  = ~n.wf & ~n.rsp.bvalid;
      n.rsp.arready = ~n.rsp.rvalid;

      // Keyboard matcher: any key or stored password sequences
      if (ps2.kbd_valid && s.ctrl.kbd_en) begin
         if (s.ctrl.kbd_any) begin
            // A byte after the break prefix is a release, not a press
            kb_hit   = (ps2.kbd_byte != KEY_BREAK) && !s.anybrk;
            n.anybrk = (ps2.kbd_byte == KEY_BREAK);
         end else begin
            for (int i = 0; i < PW_SETS; i++) begin
               pi = 6'(i * PW_LEN);
               // Stored bytes are make, F0, make per key, compared literally
               if (ps2.kbd_byte == s.pw[pi + 6'(s.ptr[i])]) begin
                  np = s.ptr[i] + 4'h1;
               end else if (ps2.kbd_byte == s.pw[pi]) begin
                  np = 4'h1;
               end else begin
                  np = 4'h0;
               end
               n.ptr[i] = np;
               // Zero byte ends a short password; empty set never matches
               if (s.pw[pi] != 8'h00 && (np == 4'(PW_LEN) ||
                   (np != 4'h0 && s.pw[pi + 6'(np)] == 8'h00))) begin
                  kb_hit = 1'b1;
               end
            end
            if (kb_hit) n.ptr = '0;
         end
      end

      // Mouse matcher: clicks are rising button edges between packets
      cl = ps2.ms_valid & ps2.ms_left & ~s.ms_prev[0];
      cr = ps2.ms_valid & ps2.ms_right & ~s.ms_prev[1];
      ck = s.ctrl.ms_right ? cr : cl;
      if (ps2.ms_valid) n.ms_prev = {ps2.ms_right, ps2.ms_left};
      if (s.ctrl.ms_en) begin
         if (s.ctrl.ms_any) begin
            ms_hit = s.ctrl.ms_single ?
                     (cl | cr | (ps2.ms_valid & ps2.ms_move)) : (cl | cr);
         end else if (s.ctrl.ms_single) begin
            ms_hit = ck;
         end else begin
            // No time window between the two clicks; kept simple
            ms_hit = ck & s.ms_cnt;
            if (ck) n.ms_cnt = ~s.ms_cnt;
         end
      end

      // Wake sources into sticky flags; set wins over a clear
      set = {src.uart_ring_indicate, src.watchdog_timeout_event,
             src.hwm_irq, src.ir_irq, src.uart_irq,
             src.consumer_infrared, src.wake_capable_gpio ^ s.gpio_q,
             kb_hit, ms_hit};
      n.gpio_q = src.wake_capable_gpio;
      if (!sleep_state3_n) set = set & SRC_S3_MASK;
      n.stat = (s.stat & ~clr) | set;
      // Wake line toward the chipset, live in every sleep state
      n.wake_n = ~(s.ctrl.gen_en & (|(n.stat & n.en)));

      // Infrared wake flag: arm on 11b, clear on following 00b
      if (s.ctrl.cir_clr == CIR_ARM) begin
         n.cir_arm = 1'b1;
      end else if (s.ctrl.cir_clr == CIR_FIRE && s.cir_arm) begin
         n.cir_arm  = 1'b0;
         n.cir_flag = 1'b0;
      end
      if (src.consumer_infrared) n.cir_flag = 1'b1;

      // Remember on/off state as main power collapses
      n.mains_q = main_supply_ok;
      if (s.mains_q && !main_supply_ok) n.prev_on = sleep_state3_n;
      n.son_n = ~sleep_state3_n;

      // Resume reset sequence and restore decision
      unique case (s.seq)
         SEQ_DOWN: begin
            n.cnt = '0;
            if (standby_supply_ok) n.seq = SEQ_DELAY;
         end
         SEQ_DELAY: begin
            n.cnt = s.cnt + CNT_W'(1);
            if (s.cnt == CNT_W'(RSM_CYC - 1)) n.seq = SEQ_RESTORE;
         end
         SEQ_RESTORE: begin
            n.seq = SEQ_UP;
            unique case (s.ctrl.policy)
               POL_OFF:  turn_on = 1'b0;
               POL_ON:   turn_on = 1'b1;
               POL_PREV: turn_on = s.prev_on;
               POL_USER: turn_on = ~s.ctrl.user_off;
            endcase
         end
         SEQ_UP: ;
      endcase
      if (!standby_supply_ok) n.seq = SEQ_DOWN;
      n.rsm_n = (n.seq == SEQ_RESTORE) || (n.seq == SEQ_UP);

      // Power button: pass-through plus a fixed wake pulse
      if (((kb_hit || ms_hit) && !sleep_state3_n) || turn_on) begin
         n.pb_cnt = CNT_W'(PB_CYC);
      end else if (s.pb_cnt != '0) begin
         n.pb_cnt = s.pb_cnt - CNT_W'(1);
      end
      n.pbo_n = power_button_in_n & (n.pb_cnt == '0);
   end

   // Single state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= ST_RST;
      end else begin
         s <= n;
      end
   end

   // Every output straight from the state register
   assign axi_rsp            = s.rsp;
   assign wake_event_out_n   = s.wake_n;
   assign power_button_out_n = s.pbo_n;
   assign supply_on_n        = s.son_n;
   assign resume_reset_n     = s.rsm_n;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_gen_off;
      !s.ctrl.gen_en |=> wake_event_out_n;
   endproperty
   a_gen_off: assert property (p_gen_off)
      else $error("wake line active with global enable off");

   property p_wake_on;
      s.ctrl.gen_en && (|(s.stat & s.en)) && !wr |=> !wake_event_out_n;
   endproperty
   a_wake_on: assert property (p_wake_on)
      else $error("wake line idle with an enabled flag set");

   property p_w1c;
      wr && s.awa == OFS_STAT_A && s.ws[0] && s.wd[1] && !set[1]
         |=> !s.stat[1];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("status flag survived a write of one");

   // Watches the GPIO flag, which only the first plain-source step raises, awake or asleep
   property p_sticky;
      s.stat[2] && !(wr && s.awa == OFS_STAT_A) |=> s.stat[2];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("status flag lost without a clear");

   property p_s3_mask;
      !sleep_state3_n && !s.stat[4] && !s.stat[7] |=> !s.stat[4] && !s.stat[7];
   endproperty
   a_s3_mask: assert property (p_s3_mask)
      else $error("awake-only source flagged in deep sleep");

   property p_pb_pass;
      !power_button_in_n |=> !power_button_out_n;
   endproperty
   a_pb_pass: assert property (p_pb_pass)
      else $error("power button input low not passed through");

   property p_pb_wake;
      (kb_hit || ms_hit) && !sleep_state3_n |=> !power_button_out_n [*2];
   endproperty
   a_pb_wake: assert property (p_pb_wake)
      else $error("no power button pulse after a wake match");

   property p_pb_end;
      s.pb_cnt == CNT_W'(1) && power_button_in_n && !kb_hit && !ms_hit &&
         !turn_on |=> power_button_out_n;
   endproperty
   a_pb_end: assert property (p_pb_end)
      else $error("power button pulse longer than its count");

   property p_kbd_off;
      !s.ctrl.kbd_en |-> !kb_hit;
   endproperty
   a_kbd_off: assert property (p_kbd_off)
      else $error("keyboard wake while disabled");

   property p_rsm_drop;
      !standby_supply_ok |=> !resume_reset_n;
   endproperty
   a_rsm_drop: assert property (p_rsm_drop)
      else $error("resume reset high without standby power");

   property p_rsm_rise;
      $rose(resume_reset_n) |-> $past(s.cnt) == CNT_W'(RSM_CYC - 1);
   endproperty
   a_rsm_rise: assert property (p_rsm_rise)
      else $error("resume reset released before its delay");

   property p_cir_set;
      src.consumer_infrared |=> s.cir_flag;
   endproperty
   a_cir_set: assert property (p_cir_set)
      else $error("infrared wake flag not set");

endmodule : wpec_top
`default_nettype wire

/* File: verification/wpec_chipset.sv */
// Purpose: Chipset and supply model facing the wake block.
// Assumes: Sleep requests and AC loss are commanded by the bench.
// Notes:   Counts power button low cycles so the bench can judge pulses.
`timescale 1ns/1ps
`default_nettype none
module wpec_chipset (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        sleep_req,
   input  wire logic        ac_fail,
   input  wire logic        cnt_clr,
   input  wire logic        power_button_out_n,
   input  wire logic        supply_on_n,
   output logic             sleep_state3_n,
   output logic             main_supply_ok,
   output logic [15:0]      pb_low_cnt
);
   // Rails lag the control lines by a cycle, so the main supply falls
   // after the sleep line when the system goes to sleep on its own
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sleep_state3_n <= 1'b0;
         main_supply_ok <= 1'b0;
         pb_low_cnt     <= 16'h0000;
      end else begin
         sleep_state3_n <= !sleep_req;
         main_supply_ok <= !ac_fail && !supply_on_n;
         pb_low_cnt     <= cnt_clr ? 16'h0000
                         : pb_low_cnt + 16'(!power_button_out_n);
      end
   end
endmodule : wpec_chipset
`default_nettype wire

/* File: verification/wake_power_event_control_tb.sv */
// Purpose: Self-checking bench of the wake and power event block.
// Assumes: Short counts, resume delay 20 cycles and wake pulse 4 cycles.
// Notes:   Expected values are worked out here from integers.
`timescale 1ns/1ps
`default_nettype none
module wake_power_event_control_tb import wpec_pkg::*;;
   localparam int RSM = 20;
   localparam int PB  = 4;
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   wpec_axi_req_s req = '0;
   wpec_axi_rsp_s rsp;
   wpec_src_s     src = '0;
   wpec_ps2_s     ps2 = '0;
   logic          pbin_n = 1'b1, stby = 1'b0, sreq = 1'b0;
   logic          acf = 1'b0, clr = 1'b0, s;
   logic          slp_n, main_ok, wake_n, pbo_n, son_n, rsm_n;
   logic [15:0]   pbc;
   logic [31:0]   rd;
   logic [1:0]    rr, ge;
   logic [7:0]    ad;
   logic [7:0]    pw [6] = '{8'h16, 8'hF0, 8'h16, 8'h1E, 8'hF0, 8'h1E};
   wpec_ctrl_s    cv;
   int            miscompares = 0, samples_checked = 0;
   int            i, k, n, b, f, tn = 0;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   wpec_top #(.RSM_CYC(RSM), .PB_CYC(PB)) u_dut (.clk(clk), .nrst(nrst),
      .axi_req(req), .axi_rsp(rsp), .src(src), .ps2(ps2),
      .power_button_in_n(pbin_n), .sleep_state3_n(slp_n),
      .main_supply_ok(main_ok), .standby_supply_ok(stby),
      .wake_event_out_n(wake_n), .power_button_out_n(pbo_n),
      .supply_on_n(son_n), .resume_reset_n(rsm_n));
   wpec_chipset u_cs (.clk(clk), .nrst(nrst), .sleep_req(sreq),
      .ac_fail(acf), .cnt_clr(clr), .power_button_out_n(pbo_n),
      .supply_on_n(son_n), .sleep_state3_n(slp_n),
      .main_supply_ok(main_ok), .pb_low_cnt(pbc));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
   endtask : cyc

   task automatic td;
      tn++;
      $display("test %0d done", tn);
   endtask : td

   // Address and data go out together; each drops once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d,
               wstrb: 4'hF, bready: 1'b1, default: '0};
      do begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      rr = rsp.bresp;
      req.bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
      do begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask : rdr

   task automatic wc;
      wr(OFS_CTRL, {20'h00000, cv});
   endtask : wc

   // Clearing takes two edges so counting restarts cleanly
   task automatic clrc;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      @(posedge clk);
   endtask : clrc

   // One strobed keyboard byte or mouse packet, spaced past a wake pulse
   task automatic pkt(input wpec_ps2_s p);
      @(posedge clk);
      ps2 <= p;
      @(posedge clk);
      ps2 <= '0;
      cyc(PB + 4);
   endtask : pkt

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   // Watchdog: the whole sequence needs well under ten thousand cycles
   initial begin
      cyc(40000);
      miscompares++;
      print_verdict();
   end

   initial begin
      void'($urandom(57655));
      cyc(2);
      nrst <= 1'b1;
      rdr(OFS_CTRL);
      chk(rd, {20'h00000, CTRL_RST});
      rdr(8'h40);
      chk(rd, 32'h00000000);
      chk(rr, RESP_SLVERR);
      wr(8'h40, 32'hFFFFFFFF);
      chk(rr, RESP_SLVERR);
      td();
      // AC loss and return under every restore policy
      for (k = 0; k < 5; k++) begin
         s = $urandom;
         sreq <= 1'b0;
         cyc(4);
         sreq <= s;
         cv = CTRL_RST;
         cv.policy = (k == 4) ? POL_USER : 2'(k);
         cv.user_off = (k == 3);
         wc();
         acf <= 1'b1;
         stby <= 1'b0;
         cyc(2);
         chk(rsm_n, 1'b0);
         clrc();
         acf <= 1'b0;
         stby <= 1'b1;
         n = 0;
         while (rsm_n !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         chk(n >= RSM && n <= RSM + 4, 1'b1);
         cyc(PB + 6);
         f = (k == 1 || k == 4 || (k == 2 && !s));
         chk(pbc, f ? PB : 0);
      end
      td();
      // Every plain source, asleep or awake, with random enables
      for (i = 0; i < 7; i++) begin
         s = $urandom;
         ge = $urandom;
         sreq <= s;
         ad = (i < 2) ? OFS_STAT_A : OFS_STAT_B;
         b = (i < 2) ? i + 2 : 6 - i;
         f = !s || i < 2;
         cv = CTRL_RST;
         cv.gen_en = ge[0];
         wc();
         wr(ad, 32'h1 << b);
         wr(ad + 8'h08, 32'(ge[1]) << b);
         cyc(3);
         src <= wpec_src_s'(7'h01 << i);
         @(posedge clk);
         src <= '0;
         cyc(3);
         rdr(ad);
         chk(rd, 32'(f) << b);
         chk(wake_n, !(f && ge[0] && ge[1]));
         chk(son_n, s);
         if (i == 1) begin
            rdr(OFS_INFO);
            chk(rd[0], 1'b1);
            cv.cir_clr = CIR_ARM;
            wc();
            cv.cir_clr = CIR_FIRE;
            wc();
            cyc(2);
            rdr(OFS_INFO);
            chk(rd[0], 1'b0);
         end
         wr(ad, 32'h1 << b);
         rdr(ad);
         chk(rd, 32'h00000000);
         chk(wake_n, 1'b1);
         wr(ad + 8'h08, 32'h00000000);
      end
      td();
      // Keyboard wake while asleep: any key, disabled, then password
      sreq <= 1'b1;
      cv = CTRL_RST;
      cv.kbd_en = 1'b1;
      wc();
      clrc();
      pkt({1'b1, 8'h45, 4'h0});
      pkt({1'b1, KEY_BREAK, 4'h0});
      pkt({1'b1, 8'h45, 4'h0});
      chk(pbc, PB);
      cv.kbd_en = 1'b0;
      wc();
      clrc();
      pkt({1'b1, 8'h45, 4'h0});
      chk(pbc, 0);
      for (n = 0; n < 15; n++) begin
         wr(OFS_PW_IDX, 32'h30 + n);
         wr(OFS_PW_DATA, (n < 6) ? {24'h0, pw[n]} : 32'h0);
      end
      wr(OFS_PW_IDX, 32'h31);
      rdr(OFS_PW_DATA);
      chk(rd, 32'h000000F0);
      cv.kbd_en = 1'b1;
      cv.kbd_any = 1'b0;
      wc();
      clrc();
      for (n = 0; n < 6; n++) pkt({1'b1, pw[n], 4'h0});
      chk(pbc, PB);
      // Keyboard flag was raised by the matches; clear it by writing one
      rdr(OFS_STAT_A);
      chk(rd[1], 1'b1);
      wr(OFS_STAT_A, 32'h00000002);
      rdr(OFS_STAT_A);
      chk(rd[1], 1'b0);
      td();
      // Every mouse selection, then the mouse wake disabled
      for (k = 0; k < 9; k++) begin
         cv = CTRL_RST;
         cv.ms_en = (k < 8);
         cv.ms_any = k[2];
         cv.ms_right = k[1];
         cv.ms_single = k[0];
         n = !cv.ms_en ? 0 : cv.ms_any ? (cv.ms_single ? 3 : 2)
           : cv.ms_right ? 0 : (cv.ms_single ? 2 : 1);
         wc();
         clrc();
         pkt({9'h000, 4'b1001});
         for (i = 0; i < 2; i++) begin
            pkt({9'h000, 4'b1100});
            pkt({9'h000, 4'b1000});
         end
         chk(pbc, n * PB);
      end
      td();
      // Button pass-through for a random press length
      n = 3 + $urandom % 8;
      clrc();
      pbin_n <= 1'b0;
      cyc(n);
      pbin_n <= 1'b1;
      cyc(4);
      chk(pbc, n);
      td();
      print_verdict();
   end
endmodule : wake_power_event_control_tb
`default_nettype wire
